// ### rtl/led_ctrl_pkg.sv
// constants shared by the led driver control register group
package led_ctrl_pkg;

  // register addresses
  localparam logic [6:0] ADDR_STATUS3 = 7'h05;
  localparam logic [6:0] ADDR_THERMAL_WARN_LIMIT = 7'h06;
  localparam logic [6:0] ADDR_SLEEP_CONTROL = 7'h07;
  localparam logic [6:0] ADDR_CH1_CURRENT_LOW = 7'h08;
  localparam logic [6:0] ADDR_CH1_CURRENT_HIGH = 7'h09;
  localparam logic [6:0] ADDR_CH2_CURRENT_LOW = 7'h0A;
  localparam logic [6:0] ADDR_CH2_CURRENT_HIGH = 7'h0B;
  localparam logic [6:0] ADDR_PWM_CLOCK_DIVIDER = 7'h0C;

  // reset values
  localparam logic [7:0] THERMAL_WARN_LIMIT_RST = 8'h8A;
  localparam logic [1:0] SLEEP_FIELD_RST = 2'h0;
  localparam logic [9:0] CURRENT_CODE_RST = 10'h000;
  localparam logic [2:0] DIV_SELECT_RST = 3'h4;

  // field layout
  localparam int THERMAL_WARN_BIT = 3;
  localparam int CODE_LOW_BITS = 2;
  localparam int SLEEP_BITS = 2;
  localparam int DIV_SEL_BITS = 3;
  localparam int TEMP_BITS = 10;
  localparam int TEMP_KEEP_LSB = 2;

  // sleep command encodings
  localparam logic [1:0] SLEEP_CMD_EXIT = 2'h0;
  localparam logic [1:0] SLEEP_CMD_ENTER = 2'h1;

  // serial frame layout: write flag, 7-bit address, 8-bit data
  localparam int FRAME_BITS = 16;
  localparam int CMD_BITS = 8;
  localparam logic [4:0] BIT_COUNT_CMD = 5'h08;
  localparam logic [4:0] BIT_COUNT_FRAME = 5'h10;

  // oscillator that feeds the pwm clock divider
  localparam longint OSC_FREQ_HZ = 10_800_000;
  localparam int DIV_COUNT_BITS = 7;

  // divide ratio for each divider select code
  function automatic logic [DIV_COUNT_BITS-1:0] div_ratio(input logic [2:0] sel);
    logic [DIV_COUNT_BITS-1:0] r;
    r = 7'h10;
    unique case (sel)
      3'h0: r = 7'h07;
      3'h1: r = 7'h08;
      3'h2: r = 7'h0A;
      3'h3: r = 7'h0C;
      3'h4: r = 7'h10;
      3'h5: r = 7'h18;
      3'h6: r = 7'h31;
      3'h7: r = 7'h62;
    endcase
    return r;
  endfunction

endpackage

// ### rtl/pwm_clock_divider.sv
// divides oscillator edges down to the internal pwm generator tick
`timescale 1ns/1ps
`default_nettype none

module pwm_clock_divider
  import led_ctrl_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic osc_edge,
  input wire logic [DIV_SEL_BITS-1:0] div_sel,
  output logic pwm_tick_q
);

  logic [DIV_COUNT_BITS-1:0] cnt_q, cnt_d;
  logic pwm_tick_d;

  // count oscillator edges; a new select moves the current wrap point at once, and
  // a count that already passed the new ratio wraps on the next edge
  always_comb begin
    cnt_d = cnt_q;
    pwm_tick_d = 1'b0;
    if (osc_edge) begin
      if (cnt_q >= div_ratio(div_sel) - 7'h01) begin
        cnt_d = '0;
        pwm_tick_d = 1'b1;
      end else begin
        cnt_d = cnt_q + 7'h01;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= '0;
      pwm_tick_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      pwm_tick_q <= pwm_tick_d;
    end
  end

endmodule

`default_nettype wire

// ### rtl/led_driver_control_regs.sv
// serial-accessed control register group of a dual-channel led driver
`timescale 1ns/1ps
`default_nettype none

module led_driver_control_regs
  import led_ctrl_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic spi_sclk,
  input wire logic spi_cs_n,
  input wire logic spi_mosi,
  output logic spi_miso_q,
  output logic spi_miso_oe_n_q,
  input wire logic osc_clk,
  input wire logic [TEMP_BITS-1:0] temp_code,
  input wire logic temp_valid,
  output logic thermal_warn_flag_q,
  output logic [7:0] temp_msb_q,
  output logic sleep_mode_q,
  output logic [9:0] ch1_current_code_q,
  output logic [9:0] ch2_current_code_q,
  output logic [DIV_SEL_BITS-1:0] pwm_clock_divide_select_q,
  output logic pwm_tick_q
);

  // ---------------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------------
  logic [3:0] sync1_q, sync2_q;
  logic sclk_prev_q;
  logic [3:0] sync1_d, sync2_d;
  logic sclk_prev_d;
  logic osc_prev_q, osc_prev_d;
  logic sclk_s, cs_n_s, mosi_s, osc_s;
  logic sclk_rise, sclk_fall, osc_edge;

  // stage one is only read by stage two; edge detectors look at stage two
  always_comb begin
    sync1_d = {osc_clk, spi_mosi, spi_cs_n, spi_sclk};
    sync2_d = sync1_q;
    sclk_prev_d = sync2_q[0];
    osc_prev_d = sync2_q[3];
  end

  // reset levels match the idle pins (cs_n high, sclk low), so no false edge follows reset
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sync1_q <= 4'h2;
      sync2_q <= 4'h2;
      sclk_prev_q <= 1'b0;
      osc_prev_q <= 1'b0;
    end else begin
      sync1_q <= sync1_d;
      sync2_q <= sync2_d;
      sclk_prev_q <= sclk_prev_d;
      osc_prev_q <= osc_prev_d;
    end
  end

  assign sclk_s = sync2_q[0];
  assign cs_n_s = sync2_q[1];
  assign mosi_s = sync2_q[2];
  assign osc_s = sync2_q[3];
  assign sclk_rise = !cs_n_s && sclk_s && !sclk_prev_q;
  assign sclk_fall = !cs_n_s && !sclk_s && sclk_prev_q;
  assign osc_edge = osc_s && !osc_prev_q;

  // ---------------------------------------------------------------------
  // serial frame engine
  // ---------------------------------------------------------------------
  logic [4:0] bit_cnt_q, bit_cnt_d;
  logic [FRAME_BITS-2:0] rx_q, rx_d;
  logic [7:0] tx_q, tx_d;
  logic wr_flag_q, wr_flag_d;
  logic [6:0] addr_q, addr_d;
  logic spi_miso_d, spi_miso_oe_n_d;
  logic cmd_done, frame_done;
  logic [FRAME_BITS-1:0] shift_in;

  // a frame cut short by cs_n never reaches the sixteenth rise, so it writes nothing
  assign shift_in = {rx_q, mosi_s};
  assign cmd_done = sclk_rise && (bit_cnt_q == BIT_COUNT_CMD - 5'h01);
  assign frame_done = sclk_rise && (bit_cnt_q == BIT_COUNT_FRAME - 5'h01);

  // shift in on sclk rise, shift out on sclk fall (mode 0, msb first)
  always_comb begin
    bit_cnt_d = bit_cnt_q;
    rx_d = rx_q;
    tx_d = tx_q;
    wr_flag_d = wr_flag_q;
    addr_d = addr_q;
    spi_miso_d = spi_miso_q;
    spi_miso_oe_n_d = cs_n_s;
    if (cs_n_s) begin
      bit_cnt_d = '0;
      tx_d = 8'h00;
      spi_miso_d = 1'b0;
    end else begin
      if (sclk_rise) begin
        rx_d = shift_in[FRAME_BITS-2:0];
        if (bit_cnt_q != BIT_COUNT_FRAME) begin
          bit_cnt_d = bit_cnt_q + 5'h01;
        end
        if (cmd_done) begin
          wr_flag_d = shift_in[CMD_BITS-1];
          addr_d = shift_in[6:0];
          tx_d = read_mux(shift_in[6:0]);
        end
      end
      if (sclk_fall && bit_cnt_q >= BIT_COUNT_CMD) begin
        spi_miso_d = tx_q[7];
        tx_d = {tx_q[6:0], 1'b0};
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bit_cnt_q <= '0;
      rx_q <= '0;
      tx_q <= 8'h00;
      wr_flag_q <= 1'b0;
      addr_q <= '0;
      spi_miso_q <= 1'b0;
      spi_miso_oe_n_q <= 1'b1;
    end else begin
      bit_cnt_q <= bit_cnt_d;
      rx_q <= rx_d;
      tx_q <= tx_d;
      wr_flag_q <= wr_flag_d;
      addr_q <= addr_d;
      spi_miso_q <= spi_miso_d;
      spi_miso_oe_n_q <= spi_miso_oe_n_d;
    end
  end

  // ---------------------------------------------------------------------
  // control registers
  // ---------------------------------------------------------------------
  logic [7:0] thermal_warn_limit_q, thermal_warn_limit_d;
  logic [SLEEP_BITS-1:0] sleep_field_q, sleep_field_d;
  logic sleep_mode_d;
  logic [9:0] ch1_current_code_d, ch2_current_code_d;
  logic [DIV_SEL_BITS-1:0] pwm_clock_divide_select_d;
  logic wr_en;
  logic [7:0] wr_data;

  // places a low register byte into the two lsbs of a current code
  function automatic logic [9:0] merge_low(input logic [9:0] code, input logic [7:0] data);
    logic [9:0] v;
    v = code;
    v[CODE_LOW_BITS-1:0] = data[CODE_LOW_BITS-1:0];
    return v;
  endfunction

  // places a high register byte into the eight msbs of a current code
  function automatic logic [9:0] merge_high(input logic [9:0] code, input logic [7:0] data);
    logic [9:0] v;
    v = code;
    v[9:CODE_LOW_BITS] = data;
    return v;
  endfunction

  // upper eight bits of a current code, as its high register reads
  function automatic logic [7:0] code_high(input logic [9:0] code);
    return code[9:CODE_LOW_BITS];
  endfunction

  // read data of a register; reserved bits come back as zero
  function automatic logic [7:0] read_mux(input logic [6:0] a);
    logic [7:0] v;
    v = 8'h00;
    unique case (a)
      ADDR_STATUS3: v[THERMAL_WARN_BIT] = thermal_warn_flag_q;
      ADDR_THERMAL_WARN_LIMIT: v = thermal_warn_limit_q;
      ADDR_SLEEP_CONTROL: v[SLEEP_BITS-1:0] = sleep_field_q;
      ADDR_CH1_CURRENT_LOW: v[CODE_LOW_BITS-1:0] = ch1_current_code_q[CODE_LOW_BITS-1:0];
      ADDR_CH1_CURRENT_HIGH: v = code_high(ch1_current_code_q);
      ADDR_CH2_CURRENT_LOW: v[CODE_LOW_BITS-1:0] = ch2_current_code_q[CODE_LOW_BITS-1:0];
      ADDR_CH2_CURRENT_HIGH: v = code_high(ch2_current_code_q);
      ADDR_PWM_CLOCK_DIVIDER: v[DIV_SEL_BITS-1:0] = pwm_clock_divide_select_q;
      default: v = 8'h00;
    endcase
    return v;
  endfunction

  // a write lands when the sixteenth bit of a write frame is taken
  assign wr_en = frame_done && wr_flag_q;
  assign wr_data = shift_in[7:0];

  // reserved bits of each write are simply not stored
  always_comb begin
    thermal_warn_limit_d = thermal_warn_limit_q;
    sleep_field_d = sleep_field_q;
    sleep_mode_d = sleep_mode_q;
    ch1_current_code_d = ch1_current_code_q;
    ch2_current_code_d = ch2_current_code_q;
    pwm_clock_divide_select_d = pwm_clock_divide_select_q;
    if (wr_en) begin
      unique case (addr_q)
        ADDR_THERMAL_WARN_LIMIT: thermal_warn_limit_d = wr_data;
        ADDR_SLEEP_CONTROL: begin
          sleep_field_d = wr_data[SLEEP_BITS-1:0];
          if (wr_data[SLEEP_BITS-1:0] == SLEEP_CMD_EXIT) begin
            sleep_mode_d = 1'b0;
          end else if (wr_data[SLEEP_BITS-1:0] == SLEEP_CMD_ENTER) begin
            sleep_mode_d = 1'b1;
          end
        end
        ADDR_CH1_CURRENT_LOW: ch1_current_code_d = merge_low(ch1_current_code_q, wr_data);
        ADDR_CH1_CURRENT_HIGH: ch1_current_code_d = merge_high(ch1_current_code_q, wr_data);
        ADDR_CH2_CURRENT_LOW: ch2_current_code_d = merge_low(ch2_current_code_q, wr_data);
        ADDR_CH2_CURRENT_HIGH: ch2_current_code_d = merge_high(ch2_current_code_q, wr_data);
        ADDR_PWM_CLOCK_DIVIDER: pwm_clock_divide_select_d = wr_data[DIV_SEL_BITS-1:0];
        default: ; // unmapped and read-only addresses ignore writes
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      thermal_warn_limit_q <= THERMAL_WARN_LIMIT_RST;
      sleep_field_q <= SLEEP_FIELD_RST;
      sleep_mode_q <= 1'b0;
      ch1_current_code_q <= CURRENT_CODE_RST;
      ch2_current_code_q <= CURRENT_CODE_RST;
      pwm_clock_divide_select_q <= DIV_SELECT_RST;
    end else begin
      thermal_warn_limit_q <= thermal_warn_limit_d;
      sleep_field_q <= sleep_field_d;
      sleep_mode_q <= sleep_mode_d;
      ch1_current_code_q <= ch1_current_code_d;
      ch2_current_code_q <= ch2_current_code_d;
      pwm_clock_divide_select_q <= pwm_clock_divide_select_d;
    end
  end

  // ---------------------------------------------------------------------
  // thermal warning
  // ---------------------------------------------------------------------
  logic thermal_warn_flag_d;
  logic [7:0] temp_msb_d;
  logic warn_set, warn_clear;

  // the two lsbs of the conversion are dropped before compare and readout
  assign warn_set = temp_valid && (temp_code[TEMP_BITS-1:TEMP_KEEP_LSB] > thermal_warn_limit_q);
  // clear on the read of status 3, taken when its data byte is loaded
  assign warn_clear = cmd_done && !shift_in[CMD_BITS-1] && (shift_in[6:0] == ADDR_STATUS3);

  // a warning in the very cycle of the clearing read is kept
  always_comb begin
    thermal_warn_flag_d = thermal_warn_flag_q;
    temp_msb_d = temp_msb_q;
    if (warn_clear) begin
      thermal_warn_flag_d = 1'b0;
    end
    if (warn_set) begin
      thermal_warn_flag_d = 1'b1;
    end
    if (temp_valid) begin
      temp_msb_d = temp_code[TEMP_BITS-1:TEMP_KEEP_LSB];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      thermal_warn_flag_q <= 1'b0;
      temp_msb_q <= 8'h00;
    end else begin
      thermal_warn_flag_q <= thermal_warn_flag_d;
      temp_msb_q <= temp_msb_d;
    end
  end

  // ---------------------------------------------------------------------
  // pwm generator clock
  // ---------------------------------------------------------------------
  // counts synchronised oscillator edges, so osc_clk must stay well below clk/2
  pwm_clock_divider u_div (
    .clk(clk),
    .rst_n(rst_n),
    .osc_edge(osc_edge),
    .div_sel(pwm_clock_divide_select_q),
    .pwm_tick_q(pwm_tick_q)
  );

endmodule

`default_nettype wire

// ### tb/led_driver_control_regs_sva.sv
// assertion checker for the led driver control register group
`timescale 1ns/1ps
`default_nettype none

module led_ctrl_regs_chk
  import led_ctrl_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic spi_sclk,
  input wire logic spi_cs_n,
  input wire logic spi_mosi,
  input wire logic spi_miso_q,
  input wire logic spi_miso_oe_n_q,
  input wire logic osc_clk,
  input wire logic [TEMP_BITS-1:0] temp_code,
  input wire logic temp_valid,
  input wire logic thermal_warn_flag_q,
  input wire logic [7:0] temp_msb_q,
  input wire logic sleep_mode_q,
  input wire logic [9:0] ch1_current_code_q,
  input wire logic [9:0] ch2_current_code_q,
  input wire logic [DIV_SEL_BITS-1:0] pwm_clock_divide_select_q,
  input wire logic pwm_tick_q
);
  // ----------------------------------------
  // properties
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  chk_reset_state: assert property ($rose(rst_n) |-> !sleep_mode_q && ch1_current_code_q == 10'h000 &&
    ch2_current_code_q == 10'h000 && pwm_clock_divide_select_q == 3'h4 && !thermal_warn_flag_q)
    else $error("state after reset is wrong");
  chk_temp_keep: assert property (temp_valid |=> {2'b00, temp_msb_q} == ($past(temp_code) >> 2))
    else $error("temperature msb not kept");
  chk_warn_cause: assert property ($rose(thermal_warn_flag_q) |-> $past(temp_valid))
    else $error("warning flag set without a conversion");
  chk_warn_high: assert property (temp_valid && temp_code[9:2] == 8'hFF |=> thermal_warn_flag_q)
    else $error("full scale temperature did not warn");
  // registers may only move while a frame is selected; cs_n seen through the synchroniser
  chk_sleep_frame: assert property ($changed(sleep_mode_q) |-> !$past(spi_cs_n, 3))
    else $error("sleep state moved outside a frame");
  chk_code_frame: assert property ($changed(ch1_current_code_q) || $changed(ch2_current_code_q)
    |-> !$past(spi_cs_n, 3)) else $error("current code moved outside a frame");
  chk_sel_frame: assert property ($changed(pwm_clock_divide_select_q) |-> !$past(spi_cs_n, 3))
    else $error("divider select moved outside a frame");
  chk_tick_pulse: assert property (pwm_tick_q |=> !pwm_tick_q)
    else $error("pwm tick longer than one cycle");
  chk_miso_release: assert property (spi_cs_n [*5] |-> spi_miso_oe_n_q && !spi_miso_q)
    else $error("miso driven while deselected");
  chk_miso_drive: assert property (!spi_cs_n [*5] |-> !spi_miso_oe_n_q)
    else $error("miso not driven while selected");

  cover property ($rose(sleep_mode_q));
  cover property ($rose(thermal_warn_flag_q));
  cover property (pwm_tick_q && pwm_clock_divide_select_q == 3'h7);
endmodule

`default_nettype wire

// ### tb/spi_host_model.sv
// serial host model that frames register reads and writes
`timescale 1ns/1ps
`default_nettype none

module spi_host_model (
  input wire logic clk,
  output logic sclk,
  output logic cs_n,
  output logic mosi,
  input wire logic miso
);
  // six clk cycles per half period keeps each level above the four-cycle minimum
  localparam int HALF = 6;

  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    mosi = 1'b0;
  end

  // mode 0 frame, msb first; read data taken at each rising serial edge of the data byte
  task automatic xfer(input logic [15:0] f, output logic [7:0] rd);
    rd = 8'h00;
    cs_n <= 1'b0;
    for (int i = 15; i >= 0; i--) begin
      mosi <= f[i];
      repeat (HALF) @(posedge clk);
      sclk <= 1'b1;
      if (i < 8) rd[i] = miso;
      repeat (HALF) @(posedge clk);
      sclk <= 1'b0;
    end
    repeat (HALF) @(posedge clk);
    cs_n <= 1'b1;
    mosi <= ~mosi; // a deselected data line must not keep the last bit
    repeat (HALF) @(posedge clk);
  endtask
endmodule

`default_nettype wire

// ### tb/tb_led_driver_control_regs.sv
// self-checking bench for the led driver control register group
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b, m) begin cmp_count++; if ((a) !== (b)) begin num_errors++; $display("[FAIL] %0t %s", $time, m); end end

module tb_led_driver_control_regs import led_ctrl_pkg::*;;
  localparam logic [7:0] RST_V [7] = '{8'h8A, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h04};
  localparam logic [7:0] MASK [7] = '{8'hFF, 8'h03, 8'h03, 8'hFF, 8'h03, 8'hFF, 8'h07};
  localparam int RATIO [8] = '{7, 8, 10, 12, 16, 24, 49, 98};
  localparam logic [1:0] SLP [8] = '{2'h0, 2'h1, 2'h2, 2'h3, 2'h0, 2'h3, 2'h1, 2'h2};
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic osc_clk = 1'b0;
  logic [1:0] osc_cnt = 2'h0;
  logic [9:0] temp_code = 10'h000;
  logic temp_valid = 1'b0;
  wire logic sclk, cs_n, mosi, miso, miso_q, miso_oe_n, flag, sleep, tick;
  wire logic [7:0] tmsb;
  wire logic [9:0] c1, c2;
  wire logic [2:0] sel;
  int num_errors = 0;
  int cmp_count = 0;
  int seed = 32'hbcfe;
  int n;
  logic s;
  logic [7:0] rd, lim;
  logic [7:0] w [7];

  always #10 clk = ~clk;
  // oscillator stand-in locked to clk so tick spacing is exactly six cycles per edge
  always @(posedge clk) begin
    osc_cnt <= (osc_cnt == 2'h2) ? 2'h0 : osc_cnt + 2'h1;
    if (osc_cnt == 2'h2) osc_clk <= ~osc_clk;
  end
  assign miso = miso_q ^ miso_oe_n; // released line shows the inverse

  spi_host_model i_spi_host_model (.clk(clk), .sclk(sclk), .cs_n(cs_n), .mosi(mosi), .miso(miso));
  led_driver_control_regs i_led_driver_control_regs (.clk(clk), .rst_n(rst_n), .spi_sclk(sclk),
    .spi_cs_n(cs_n), .spi_mosi(mosi), .spi_miso_q(miso_q), .spi_miso_oe_n_q(miso_oe_n), .osc_clk(osc_clk),
    .temp_code(temp_code), .temp_valid(temp_valid), .thermal_warn_flag_q(flag), .temp_msb_q(tmsb),
    .sleep_mode_q(sleep), .ch1_current_code_q(c1), .ch2_current_code_q(c2),
    .pwm_clock_divide_select_q(sel), .pwm_tick_q(tick));

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [9:0] code_of(input logic [7:0] hi, input logic [7:0] lo);
    return {hi, lo[1:0]};
  endfunction
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    logic [7:0] x;
    i_spi_host_model.xfer({1'b1, a, d}, x);
  endtask
  task automatic rdreg(input logic [6:0] a, output logic [7:0] d);
    i_spi_host_model.xfer({1'b0, a, 8'h00}, d);
  endtask
  task automatic temp(input logic [7:0] m);
    temp_code <= {m, 2'($random(seed))};
    temp_valid <= 1'b1;
    @(posedge clk);
    temp_valid <= 1'b0;
    repeat (2) @(posedge clk);
  endtask
  // clk cycles up to the next pwm tick, bounded
  task automatic gap(output int c);
    c = 0;
    do begin
      @(posedge clk);
      c++;
    end while (tick !== 1'b1 && c < 2000);
  endtask
  task automatic complete_run();
    if (num_errors == 0 && cmp_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    repeat (3) gap(n);
    `CHK(n, 6 * RATIO[4], "default pwm period")
    for (int i = 0; i < 7; i++) begin
      rdreg(7'(6 + i), rd);
      `CHK(rd, RST_V[i], "reset value")
    end
    rdreg(7'h20, rd);
    `CHK(rd, 8'h00, "unmapped read")
    // random writes, reserved bits random too, read back masked
    for (int k = 0; k < 3; k++) begin
      for (int i = 0; i < 7; i++) begin
        w[i] = 8'($random(seed));
        wr(7'(6 + i), w[i]);
        rdreg(7'(6 + i), rd);
        `CHK(rd, w[i] & MASK[i], "read back")
      end
      `CHK(c1, code_of(w[3], w[2]), "ch1 code")
      `CHK(c2, code_of(w[5], w[4]), "ch2 code")
      `CHK(sel, w[6][2:0], "divider select")
    end
    // every sleep command, no-effect codes between the real ones
    s = 1'b0;
    foreach (SLP[j]) begin
      wr(7'h07, {6'h00, SLP[j]});
      if (SLP[j] < 2'h2) s = SLP[j][0];
      `CHK(sleep, s, "sleep state")
    end
    // warning threshold: equal does not warn, one above does
    lim = 8'h40 + {1'b0, 7'($random(seed))};
    wr(7'h06, lim);
    rdreg(7'h05, rd);
    temp(lim);
    `CHK(flag, 1'b0, "warn at limit")
    temp(lim + 8'h01);
    `CHK(flag, 1'b1, "warn above limit")
    temp(8'hFF);
    `CHK(tmsb, 8'hFF, "temperature msb")
    rdreg(7'h05, rd);
    `CHK(rd, 8'h08, "status warn bit")
    `CHK(flag, 1'b0, "clear on read")
    rdreg(7'h05, rd);
    `CHK(rd, 8'h00, "status after clear")
    // every divider code; first ticks after a change are skipped
    for (int c = 0; c < 8; c++) begin
      wr(7'h0C, 8'(c));
      repeat (3) gap(n);
      `CHK(n, 6 * RATIO[c], "pwm tick period")
    end
    complete_run();
  end

  initial begin
    repeat (80000) @(posedge clk);
    num_errors++;
    complete_run();
  end
endmodule

bind led_driver_control_regs led_ctrl_regs_chk i_led_ctrl_regs_chk (.clk(clk), .rst_n(rst_n),
  .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi), .spi_miso_q(spi_miso_q),
  .spi_miso_oe_n_q(spi_miso_oe_n_q), .osc_clk(osc_clk), .temp_code(temp_code), .temp_valid(temp_valid),
  .thermal_warn_flag_q(thermal_warn_flag_q), .temp_msb_q(temp_msb_q), .sleep_mode_q(sleep_mode_q),
  .ch1_current_code_q(ch1_current_code_q), .ch2_current_code_q(ch2_current_code_q),
  .pwm_clock_divide_select_q(pwm_clock_divide_select_q), .pwm_tick_q(pwm_tick_q));

`default_nettype wire
